/* File: hw/tsp_pkg.sv */
// tsp_pkg: constants and carriers for the serial register port
// assumes: 16-bit registers, 10-bit address space
package tsp_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 10;
    localparam logic [4:0] ENABLE_PATTERN = 5'h1C;
    localparam int EN_HI = 15;
    localparam int EN_LO = 11;
    localparam int RW_BIT = 10;
    localparam logic [ADDR_W-1:0] ADDR_MAX = 10'h3FF;
    localparam logic [4:0] BUS_ADDR_BASE = 5'h0B;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [1:0] SYNC_RESET = 2'h3;

    typedef enum logic [1:0] {
        TSP_IDLE = 2'b00,
        TSP_CMD = 2'b01,
        TSP_DATA = 2'b10,
        TSP_IGNORE = 2'b11
    } tsp_state_e;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } tsp_wr_s;

    typedef struct packed {
        logic req;
        logic [ADDR_W-1:0] addr;
    } tsp_rd_s;
endpackage : tsp_pkg

/* File: hw/tsp_sync.sv */
// tsp_sync: three-stage input synchroniser with agreement filter
// assumes: input asynchronous to clk; output changes once stages 2 and 3 agree
`timescale 1ns/1ps
module tsp_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= INIT;
        end else if (s2 == s3) begin
            dout <= s3;
        end
    end
endmodule : tsp_sync

/* File: hw/tsp_port.sv */
// tsp_port: serial register-access slave port, sampled on the system clock
// assumes: serial clock much slower than clk (>= 4 clk per half period);
// register storage sits outside and answers reads in the cycle after req
`timescale 1ns/1ps
module tsp_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic selectN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic bus_addr_strap_hi,
    input wire logic bus_addr_strap_lo,
    output logic [6:0] busAddr,
    output tsp_pkg::tsp_wr_s regWrite,
    output tsp_pkg::tsp_rd_s regRead,
    input wire logic [tsp_pkg::WORD_W-1:0] regReadData
);
    logic sclk;
    logic selN;
    logic din;
    logic sclkPrev;
    logic selPrev;
    tsp_pkg::tsp_state_e state;
    logic [3:0] bitCnt;
    logic [tsp_pkg::WORD_W-1:0] shiftIn;
    logic [tsp_pkg::WORD_W-1:0] shiftOut;
    logic [tsp_pkg::ADDR_W-1:0] addrPtr;
    logic isRead;
    logic atMax;
    logic loadPending;
    logic [tsp_pkg::WORD_W-1:0] cmdWord;
    logic strapHi;
    logic strapLo;

    tsp_sync #(.INIT(1'b0)) syncClk (
        .clk(clk), .rst(rst), .din(serialClk), .dout(sclk)
    );
    tsp_sync #(.INIT(1'b1)) syncSel (
        .clk(clk), .rst(rst), .din(selectN), .dout(selN)
    );
    tsp_sync #(.INIT(1'b0)) syncDin (
        .clk(clk), .rst(rst), .din(serialIn), .dout(din)
    );
    // straps are pins too; a slow strap edge must not glitch the address
    tsp_sync #(.INIT(1'b0)) syncStrapHi (
        .clk(clk), .rst(rst), .din(bus_addr_strap_hi), .dout(strapHi)
    );
    tsp_sync #(.INIT(1'b0)) syncStrapLo (
        .clk(clk), .rst(rst), .din(bus_addr_strap_lo), .dout(strapLo)
    );

    // edges judged from a known previous level, so idle level is irrelevant
    logic riseEdge;
    logic fallEdge;
    logic frameStart;
    // the select edge cycle is excluded: a clock that moves to its idle
    // level together with select would otherwise count as a data edge
    assign riseEdge = sclk && !sclkPrev && !selN && !selPrev;
    assign fallEdge = !sclk && sclkPrev && !selN && !selPrev;
    assign frameStart = selPrev && !selN;
    assign cmdWord = {shiftIn[tsp_pkg::WORD_W-2:0], din};

    function automatic logic cmdValid(input logic [15:0] w);
        cmdValid = w[tsp_pkg::EN_HI:tsp_pkg::EN_LO]
            == tsp_pkg::ENABLE_PATTERN;
    endfunction : cmdValid

    always_ff @(posedge clk) begin
        if (rst) begin
            sclkPrev <= 1'b0;
            selPrev <= 1'b1;
        end else begin
            // tracked every cycle; the select edge mask keeps an idle-high clock from being an edge
            sclkPrev <= sclk;
            selPrev <= selN;
        end
    end

    // frame sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= tsp_pkg::TSP_IDLE;
            bitCnt <= tsp_pkg::BIT_CNT_RESET;
            shiftIn <= '0;
            isRead <= 1'b0;
        end else if (selN) begin
            state <= tsp_pkg::TSP_IDLE;
            bitCnt <= tsp_pkg::BIT_CNT_RESET;
        end else begin
            case (state)
                tsp_pkg::TSP_IDLE: begin
                    if (frameStart || riseEdge) begin
                        state <= tsp_pkg::TSP_CMD;
                    end
                    if (riseEdge) begin
                        shiftIn <= cmdWord;
                        bitCnt <= 4'h1;
                    end
                end
                tsp_pkg::TSP_CMD: begin
                    if (riseEdge) begin
                        shiftIn <= cmdWord;
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == tsp_pkg::BIT_LAST) begin
                            if (cmdValid(cmdWord)) begin
                                state <= tsp_pkg::TSP_DATA;
                                isRead <= cmdWord[tsp_pkg::RW_BIT];
                            end else begin
                                state <= tsp_pkg::TSP_IGNORE;
                            end
                        end
                    end
                end
                tsp_pkg::TSP_DATA: begin
                    if (riseEdge) begin
                        shiftIn <= cmdWord;
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                tsp_pkg::TSP_IGNORE: begin
                    state <= tsp_pkg::TSP_IGNORE;
                end
                default: begin
                    state <= tsp_pkg::TSP_IDLE;
                end
            endcase
        end
    end

    logic cmdDone;
    logic wordDone;
    assign cmdDone = state == tsp_pkg::TSP_CMD && riseEdge
        && bitCnt == tsp_pkg::BIT_LAST && cmdValid(cmdWord);
    assign wordDone = state == tsp_pkg::TSP_DATA && riseEdge
        && bitCnt == tsp_pkg::BIT_LAST;

    // address pointer; saturates instead of wrapping
    always_ff @(posedge clk) begin
        if (rst) begin
            addrPtr <= '0;
            atMax <= 1'b0;
        end else if (cmdDone) begin
            addrPtr <= cmdWord[tsp_pkg::ADDR_W-1:0];
            atMax <= 1'b0;
        end else if (wordDone) begin
            if (addrPtr == tsp_pkg::ADDR_MAX) begin
                atMax <= 1'b1;
            end else begin
                addrPtr <= addrPtr + 10'h001;
            end
        end
    end

    // write strobe: one cycle per complete data word of a write frame, none past the top
    always_ff @(posedge clk) begin
        if (rst) begin
            regWrite <= '0;
        end else begin
            regWrite.we <= wordDone && !isRead && !atMax;
            regWrite.addr <= addrPtr;
            regWrite.data <= cmdWord;
        end
    end

    // read request: fetch at command end and at each word boundary
    logic fetchNow;
    assign fetchNow = (cmdDone && cmdWord[tsp_pkg::RW_BIT])
        || (wordDone && isRead);
    always_ff @(posedge clk) begin
        if (rst) begin
            regRead <= '0;
        end else begin
            regRead.req <= fetchNow;
            // at the top the same register is repeated
            if (cmdDone) begin
                regRead.addr <= cmdWord[tsp_pkg::ADDR_W-1:0];
            end else if (wordDone && addrPtr != tsp_pkg::ADDR_MAX) begin
                regRead.addr <= addrPtr + 10'h001;
            end else begin
                regRead.addr <= addrPtr;
            end
        end
    end

    // data arrives one cycle after req, long before the next falling edge
    always_ff @(posedge clk) begin
        if (rst) begin
            loadPending <= 1'b0;
        end else begin
            loadPending <= regRead.req;
        end
    end

    // output shifter: new bit on each falling edge, msb first
    always_ff @(posedge clk) begin
        if (rst) begin
            shiftOut <= '0;
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else if (selN || state != tsp_pkg::TSP_DATA || !isRead) begin
            serialOutEn <= 1'b0;
            serialOut <= 1'b0;
        end else begin
            if (loadPending) begin
                shiftOut <= regReadData;
            end else if (fallEdge) begin
                serialOutEn <= 1'b1;
                serialOut <= shiftOut[tsp_pkg::WORD_W-1];
                shiftOut <= {shiftOut[tsp_pkg::WORD_W-2:0], 1'b0};
            end
        end
    end

    // two-wire variant address; target only, no drive of its own
    always_ff @(posedge clk) begin
        if (rst) begin
            busAddr <= {tsp_pkg::BUS_ADDR_BASE, 2'b00};
        end else begin
            busAddr <= {tsp_pkg::BUS_ADDR_BASE,
                strapHi, strapLo};
        end
    end
endmodule : tsp_port

/* File: bench/tsp_port_checker.sv */
// tsp_port_checker: timing relations on the serial register port
// assumes: bound to tsp_port, one clock domain, sync reset
`timescale 1ns/1ps
module tsp_port_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic selectN,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic bus_addr_strap_hi,
    input wire logic bus_addr_strap_lo,
    input wire logic [6:0] busAddr,
    input wire tsp_pkg::tsp_wr_s regWrite,
    input wire tsp_pkg::tsp_rd_s regRead
);
    logic haveWe;
    logic haveRq;
    logic [tsp_pkg::ADDR_W-1:0] lastWe;
    logic [tsp_pkg::ADDR_W-1:0] lastRq;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // raw select clears tracking; late pulses are then just not checked
    always_ff @(posedge clk) begin
        if (rst || selectN) haveWe <= 1'b0;
        else if (regWrite.we) haveWe <= 1'b1;
        if (regWrite.we) lastWe <= regWrite.addr;
    end
    always_ff @(posedge clk) begin
        if (rst || selectN) haveRq <= 1'b0;
        else if (regRead.req) haveRq <= 1'b1;
        if (regRead.req) lastRq <= regRead.addr;
    end
    chk_base_fixed: assert property (busAddr[6:2] == 5'h0b)
        else $error("bus address base wrong");
    chk_strap_follow: assert property (
        $stable({bus_addr_strap_hi, bus_addr_strap_lo})[*8]
        |-> busAddr[1:0] == {bus_addr_strap_hi, bus_addr_strap_lo})
        else $error("bus address straps not followed");
    chk_we_pulse: assert property (regWrite.we |=> !regWrite.we)
        else $error("write strobe longer than one cycle");
    chk_req_pulse: assert property (regRead.req |=> !regRead.req)
        else $error("read request longer than one cycle");
    chk_oe_idle: assert property (selectN[*8] |-> !serialOutEn)
        else $error("output driven while deselected");
    chk_out_quiet: assert property (!serialOutEn |-> !serialOut)
        else $error("output not low while undriven");
    chk_wr_step: assert property (regWrite.we && haveWe |->
        lastWe != tsp_pkg::ADDR_MAX && regWrite.addr == lastWe + 1'b1)
        else $error("write address step wrong");
    chk_rd_step: assert property (regRead.req && haveRq |->
        regRead.addr == (lastRq == tsp_pkg::ADDR_MAX ? lastRq
        : lastRq + 1'b1))
        else $error("read address step wrong");
endmodule : tsp_port_checker
bind tsp_port tsp_port_checker tsp_port_checker_inst (.clk, .rst,
    .selectN, .serialOut, .serialOutEn, .bus_addr_strap_hi,
    .bus_addr_strap_lo, .busAddr, .regWrite, .regRead);

/* File: bench/tsp_host.sv */
// tsp_host: serial bus master model, clock made from the system clock
// assumes: 800 ns serial period, clock still between frames
`timescale 1ns/1ps
module tsp_host (
    input wire logic clk,
    output logic serialClk,
    output logic selectN,
    output logic serialIn,
    input wire logic serialOut
);
    initial begin
        serialClk = 1'b0;
        selectN = 1'b1;
        serialIn = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic open(input logic idle);
        serialClk <= idle;
        selectN <= 1'b0;
        tick(4);
    endtask : open
    // whole words only: a partial word would be dropped by the port
    task automatic word(input logic [15:0] w, output logic [15:0] r);
        for (int i = 15; i >= 0; i--) begin
            serialClk <= 1'b0;
            serialIn <= w[i];
            tick(4);
            serialClk <= 1'b1;
            tick(4);
            r[i] = serialOut;
        end
    endtask : word
    task automatic close(input logic idle);
        tick(8);
        selectN <= 1'b1;
        serialClk <= idle;
        serialIn <= ~serialIn;
        tick(8);
    endtask : close
endmodule : tsp_host

/* File: bench/tsp_port_test.sv */
// tsp_port_test: scenarios for the serial register port
// assumes: register storage modelled here, answers the cycle after req
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    tests_run++; \
    if ((s) !== (e)) begin \
        mismatches++; \
        $display("[ERR] %s exp %h got %h", n, e, s); \
    end \
end
module tsp_port_test;
    logic clk;
    logic rst;
    logic serialClk;
    logic selectN;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    logic strapHi = 1'b0;
    logic strapLo = 1'b0;
    logic [6:0] busAddr;
    tsp_pkg::tsp_wr_s regWrite;
    tsp_pkg::tsp_rd_s regRead;
    logic [15:0] regReadData = 16'h0000;
    logic [15:0] mem [1024];
    int writes = 0;
    int mismatches = 0;
    int tests_run = 0;
    tsp_port tsp_port_inst (.clk(clk), .rst(rst), .serialClk(serialClk),
        .selectN(selectN), .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .bus_addr_strap_hi(strapHi),
        .bus_addr_strap_lo(strapLo), .busAddr(busAddr),
        .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData));
    tsp_host tsp_host_inst (.clk(clk), .serialClk(serialClk),
        .selectN(selectN), .serialIn(serialIn), .serialOut(serialOut));
    always @(posedge clk) begin
        if (regWrite.we === 1'b1) begin
            mem[regWrite.addr] <= regWrite.data;
            writes++;
        end
        if (regRead.req === 1'b1) regReadData <= mem[regRead.addr];
    end
    task automatic frame(input logic idle, input logic [15:0] c,
        input logic [15:0] d, input int n, output logic [15:0] r);
        tsp_host_inst.open(idle);
        tsp_host_inst.word(c, r);
        for (int i = 0; i < n; i++) tsp_host_inst.word(d + 16'(i), r);
        tsp_host_inst.close(idle);
    endtask : frame
    task automatic wr_test();
        logic [15:0] r;
        int w0;
        w0 = writes;
        // third word lands past the top address and must vanish
        // only mapped addresses are written here
        frame(1'b0, 16'he3fe, 16'h1234, 3, r);
        `CHK("wr0", 16'h1234, mem[10'h3fe])
        `CHK("wr1", 16'h1235, mem[10'h3ff])
        `CHK("wrcnt", 2, writes - w0)
    endtask : wr_test
    task automatic rd_test();
        logic [15:0] r;
        tsp_host_inst.open(1'b1);
        tsp_host_inst.word(16'he7fe, r);
        tsp_host_inst.word(16'h0000, r);
        `CHK("rd0", 16'h1234, r)
        tsp_host_inst.word(16'h0000, r);
        `CHK("rd1", 16'h1235, r)
        tsp_host_inst.word(16'h0000, r);
        `CHK("rd2", 16'h1235, r)
        tsp_host_inst.close(1'b1);
        frame(1'b0, 16'he081, 16'h0000, 1, r);
        `CHK("clr81", 16'h0000, mem[10'h081])
    endtask : rd_test
    task automatic bad_test();
        logic [15:0] r;
        int w0;
        w0 = writes;
        frame(1'b1, 16'h63fe, 16'hffff, 2, r);
        `CHK("badwr", 0, writes - w0)
        `CHK("badout", 16'h0000, r)
    endtask : bad_test
    task automatic strap_test();
        for (int i = 0; i < 4; i++) begin
            {strapHi, strapLo} <= 2'(i);
            repeat (10) @(posedge clk);
            `CHK("busAddr", {5'h0b, 2'(i)}, busAddr)
        end
    endtask : strap_test
    task automatic conclude();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        foreach (mem[i]) mem[i] = 16'(i) ^ 16'h5a5a;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        wr_test();
        rd_test();
        bad_test();
        strap_test();
        conclude();
    end
endmodule : tsp_port_test
